/* File: hw/lad_core.sv */
// LCD attribute decoder: refresh buffer, host/display arbitration, cell rendering
// Function
// - Character cells render as an 8 by 8 pel box, underscore on last row.
// - Monochrome and colour emulations each have own buffer bank and settings.
// - Text output is two levels per pel plus solid grey for black on black; graphics uses four shades.
// - Intensity bit never darkens or lightens pels, only applies chosen treatment.
// - Programmable intensity treatment: reverse, underscore, alternate font, or ignore.
// - Host and display collisions arbitrated; host completes once display fetches pause, display never corrupted.
// - Attribute table: 000000 grey, 000001 underscored in monochrome emulation only, 000111 normal, 111000 reverse, 111111 black.
// - Colour field codes black to white; intensity gives light variant, grey for black.
// - Graphics: background grey, cyan/green dark 1, magenta/red dark 2, white/brown black.
// - Black on black hidden; same non-black colours give solid reverse video.
`timescale 1ns/100ps
`default_nettype none
module lad_core #(
    parameter int CELL_AW = 12
) (
    input  wire logic               clk,
    input  wire logic               reset,
    // Emulation and setting ports
    input  wire logic               emul_colour,
    input  wire logic               graphics,
    input  wire logic               palette,
    input  wire logic [2:0]         gfx_bg,
    input  wire logic               mono_cfg_we,
    input  wire logic               colour_cfg_we,
    input  wire logic [1:0]         cfg_intens,
    // Host access to the refresh buffer
    input  wire logic               host_req,
    input  wire logic               host_we,
    input  wire logic [CELL_AW:0]   host_addr,
    input  wire logic [7:0]         host_wdata,
    output logic                    host_busy,
    output logic                    host_ack,
    output logic [7:0]              host_rdata,
    // Display fetch
    input  wire logic               disp_req,
    input  wire logic [CELL_AW-1:0] disp_cell,
    input  wire logic [2:0]         disp_row,
    output logic                    cell_valid,
    output logic [7:0]              cell_char,
    output logic                    cell_fg_dark,
    output logic                    cell_bg_dark,
    output logic                    cell_grey,
    output logic                    cell_underscore,
    output logic                    cell_alt_font,
    output logic                    cell_nondisplay,
    output logic [15:0]             gfx_shade,
    output logic [1:0]              mono_intens,
    output logic [1:0]              colour_intens
);
    localparam int DEPTH = 2 ** (CELL_AW + 1);

    // Both emulation banks, one byte per lane per cell
    logic [7:0]         char_mem [DEPTH];
    logic [7:0]         attr_mem [DEPTH];

    logic               pend;
    logic               pend_we;
    logic [CELL_AW:0]   pend_addr;
    logic [7:0]         pend_wdata;
    logic               host_go;
    logic               host_take;
    logic [CELL_AW:0]   host_idx;
    logic [CELL_AW:0]   disp_idx;
    logic               s1_valid;
    logic [2:0]         s1_row;
    logic [7:0]         s1_char;
    logic [7:0]         s1_attr;
    logic               s1_mono;
    logic               s1_gfx;
    logic [1:0]         act_intens;
    logic               d_fg;
    logic               d_bg;
    logic               d_grey;
    logic               d_ul;
    logic               d_alt;
    logic               d_nd;
    logic [15:0]        next_gfx_shade;

    // Bank picked by the active emulation, cell index below it
    assign host_idx = {emul_colour ? lad_pkg::BANK_COLOUR : lad_pkg::BANK_MONO, pend_addr[CELL_AW:1]};
    assign disp_idx = {emul_colour ? lad_pkg::BANK_COLOUR : lad_pkg::BANK_MONO, disp_cell};

    // Host takes the buffer in any cycle without a display fetch
    assign host_go  = pend && !disp_req;

    // Request still up in its acknowledge cycle is the finished one, not a new one
    assign host_take = host_req && !pend && !host_ack;

    // Intensity setting of each emulation, loaded through its own port
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            mono_intens   <= lad_pkg::INTENS_RESET;
            colour_intens <= lad_pkg::INTENS_RESET;
        end else begin
            if (mono_cfg_we) begin
                mono_intens <= cfg_intens;
            end
            if (colour_cfg_we) begin
                colour_intens <= cfg_intens;
            end
        end
    end

    // Host request held until the buffer is free
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pend       <= 1'b0;
            pend_we    <= 1'b0;
            pend_addr  <= '0;
            pend_wdata <= 8'h00;
        end else if (host_take) begin
            pend       <= 1'b1;
            pend_we    <= host_we;
            pend_addr  <= host_addr;
            pend_wdata <= host_wdata;
        end else if (host_go) begin
            pend       <= 1'b0;
        end
    end

    // Busy flag mirrors the held request
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            host_busy <= 1'b0;
        end else begin
            host_busy <= host_take || (pend && !host_go);
        end
    end

    // Buffer write port, host only
    always_ff @(posedge clk) begin
        if (host_go && pend_we) begin
            if (pend_addr[0] == lad_pkg::LANE_ATTR) begin
                attr_mem[host_idx] <= pend_wdata;
            end else begin
                char_mem[host_idx] <= pend_wdata;
            end
        end
    end

    // Host completion and read data
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            host_ack   <= 1'b0;
            host_rdata <= 8'h00;
        end else begin
            host_ack <= host_go;
            if (host_go && !pend_we) begin
                host_rdata <= (pend_addr[0] == lad_pkg::LANE_ATTR) ? attr_mem[host_idx] : char_mem[host_idx];
            end
        end
    end

    // Display fetch stage, always served first so no pel is lost
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s1_valid <= 1'b0;
            s1_row   <= 3'h0;
            s1_char  <= 8'h00;
            s1_attr  <= 8'h00;
            s1_mono  <= 1'b1;
            s1_gfx   <= 1'b0;
        end else begin
            s1_valid <= disp_req;
            if (disp_req) begin
                s1_row  <= disp_row;
                s1_char <= char_mem[disp_idx];
                s1_attr <= attr_mem[disp_idx];
                s1_mono <= !emul_colour;
                s1_gfx  <= graphics;
            end
        end
    end

    // Treatment of the emulation the fetched cell belongs to
    assign act_intens = s1_mono ? mono_intens : colour_intens;

    lad_attr_decode u_decode (
        .attr        (s1_attr),
        .mono        (s1_mono),
        .intens_mode (act_intens),
        .fg_dark     (d_fg),
        .bg_dark     (d_bg),
        .solid_grey  (d_grey),
        .underscore  (d_ul),
        .alt_font    (d_alt),
        .nondisplay  (d_nd)
    );

    // Graphics: two fetched bytes hold eight 2-bit pels, first pel in the top bits
    genvar gi;
    generate
        for (gi = 0; gi < lad_pkg::CELL_W; gi++) begin : g_pel
            logic [1:0]           pel;
            lad_pkg::lad_colour_e col;
            assign pel = (gi < 4) ? s1_char[7 - 2 * (gi % 4) -: 2] : s1_attr[7 - 2 * (gi % 4) -: 2];
            assign col = (pel == 2'h0) ? lad_pkg::lad_colour(1'b0, gfx_bg)
                                       : lad_pkg::lad_gfx_colour(palette, pel);
            // Background always grey whatever its colour
            assign next_gfx_shade[15 - 2 * gi -: 2] = (pel == 2'h0) ? lad_pkg::LAD_SH_GREY
                                                                     : lad_pkg::lad_shade(col);
        end
    endgenerate

    // Registered cell rendering: two levels plus grey fill
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cell_valid      <= 1'b0;
            cell_char       <= 8'h00;
            cell_fg_dark    <= 1'b0;
            cell_bg_dark    <= 1'b0;
            cell_grey       <= 1'b0;
            cell_underscore <= 1'b0;
            cell_alt_font   <= 1'b0;
            cell_nondisplay <= 1'b0;
            gfx_shade       <= 16'h0000;
        end else begin
            cell_valid <= s1_valid;
            if (s1_valid) begin
                cell_char       <= s1_char;
                cell_fg_dark    <= !s1_gfx && d_fg;
                cell_bg_dark    <= !s1_gfx && d_bg;
                cell_grey       <= !s1_gfx && d_grey;
                cell_underscore <= !s1_gfx && d_ul && (s1_row == lad_pkg::UL_ROW);
                cell_alt_font   <= !s1_gfx && d_alt;
                cell_nondisplay <= !s1_gfx && d_nd;
                gfx_shade       <= s1_gfx ? next_gfx_shade : 16'h0000;
            end
        end
    end

endmodule : lad_core
`default_nettype wire

/* File: hw/lad_pkg.sv */
// Shared constants, types and helper functions for the LCD attribute decoder
package lad_pkg;

    // Character cell geometry: fixed 8 x 8 pel box
    localparam int          CELL_W        = 8;
    localparam int          CELL_H        = 8;
    localparam logic [2:0]  UL_ROW        = 3'h7;   // Underscore drawn on the last pel row

    // Attribute byte field positions
    localparam int          FG_LSB        = 0;
    localparam int          INTENS_BIT    = 3;
    localparam int          BG_LSB        = 4;

    // Three-bit colour field values
    localparam logic [2:0]  COL_BLACK     = 3'h0;
    localparam logic [2:0]  COL_BLUE      = 3'h1;
    localparam logic [2:0]  COL_WHITE     = 3'h7;

    // Refresh buffer byte lanes within a cell
    localparam logic        LANE_CHAR     = 1'h0;
    localparam logic        LANE_ATTR     = 1'h1;

    // Buffer bank per emulation
    localparam logic        BANK_MONO     = 1'h0;
    localparam logic        BANK_COLOUR   = 1'h1;

    // Graphics palette selections
    localparam logic        PAL_GRN_RED   = 1'h0;
    localparam logic        PAL_CYN_MAG   = 1'h1;

    // Reset values of the intensity treatment settings
    localparam logic [1:0]  INTENS_RESET  = 2'h3;

    // Treatment of a set intensity bit
    typedef enum logic [1:0] {
        LAD_INT_REVERSE   = 2'b00,
        LAD_INT_UNDERLINE = 2'b01,
        LAD_INT_ALTFONT   = 2'b10,
        LAD_INT_IGNORE    = 2'b11
    } lad_intens_e;

    // Full colour: intensity bit above the three colour bits
    typedef enum logic [3:0] {
        LAD_BLACK      = 4'b0000, LAD_BLUE       = 4'b0001,
        LAD_GREEN      = 4'b0010, LAD_CYAN       = 4'b0011,
        LAD_RED        = 4'b0100, LAD_MAGENTA    = 4'b0101,
        LAD_BROWN      = 4'b0110, LAD_WHITE      = 4'b0111,
        LAD_GREY       = 4'b1000, LAD_LT_BLUE    = 4'b1001,
        LAD_LT_GREEN   = 4'b1010, LAD_LT_CYAN    = 4'b1011,
        LAD_LT_RED     = 4'b1100, LAD_LT_MAGENTA = 4'b1101,
        LAD_LT_BROWN   = 4'b1110, LAD_HI_WHITE   = 4'b1111
    } lad_colour_e;

    // Graphics pel shades
    typedef enum logic [1:0] {
        LAD_SH_GREY  = 2'b00,
        LAD_SH_DARK1 = 2'b01,
        LAD_SH_DARK2 = 2'b10,
        LAD_SH_BLACK = 2'b11
    } lad_shade_e;

    // Colour field plus intensity to named colour
    function automatic lad_colour_e lad_colour(input logic intens, input logic [2:0] field);
        lad_colour = lad_colour_e'({intens, field});
    endfunction : lad_colour

    // Medium resolution graphics: 2-bit pel value to colour
    function automatic lad_colour_e lad_gfx_colour(input logic pal, input logic [1:0] pel);
        case (pel)
            2'h1:    lad_gfx_colour = (pal == PAL_CYN_MAG) ? LAD_CYAN    : LAD_GREEN;
            2'h2:    lad_gfx_colour = (pal == PAL_CYN_MAG) ? LAD_MAGENTA : LAD_RED;
            2'h3:    lad_gfx_colour = (pal == PAL_CYN_MAG) ? LAD_WHITE   : LAD_BROWN;
            default: lad_gfx_colour = LAD_BLACK;
        endcase
    endfunction : lad_gfx_colour

    // Colour to LCD shade, light variants shade like their base colour
    function automatic lad_shade_e lad_shade(input lad_colour_e col);
        case (col[2:0])
            3'h2, 3'h3: lad_shade = LAD_SH_DARK1;
            3'h4, 3'h5: lad_shade = LAD_SH_DARK2;
            3'h6, 3'h7: lad_shade = LAD_SH_BLACK;
            default:    lad_shade = LAD_SH_GREY;
        endcase
    endfunction : lad_shade

endpackage : lad_pkg

/* File: hw/lad_attr_decode.sv */
// Combinational attribute byte to LCD rendering decode
`timescale 1ns/100ps
`default_nettype none
module lad_attr_decode (
    input  wire logic [7:0] attr,
    input  wire logic       mono,
    input  wire logic [1:0] intens_mode,
    output logic            fg_dark,
    output logic            bg_dark,
    output logic            solid_grey,
    output logic            underscore,
    output logic            alt_font,
    output logic            nondisplay
);
    logic [2:0] fg;
    logic [2:0] bg;
    logic       intens;
    logic       rev;

    // Split the attribute into its fields
    assign fg     = attr[lad_pkg::FG_LSB +: 3];
    assign bg     = attr[lad_pkg::BG_LSB +: 3];
    assign intens = attr[lad_pkg::INTENS_BIT];

    // Base decode, then the selected intensity treatment on top
    always_comb begin
        rev        = 1'b0;
        solid_grey = 1'b0;
        nondisplay = 1'b0;
        underscore = 1'b0;
        alt_font   = 1'b0;
        fg_dark    = 1'b1;
        bg_dark    = 1'b0;
        if (fg == lad_pkg::COL_BLACK && bg == lad_pkg::COL_BLACK) begin
            solid_grey = 1'b1;
            nondisplay = 1'b1;
            fg_dark    = 1'b0;
        end else if (fg == bg) begin
            fg_dark    = 1'b1;
            bg_dark    = 1'b1;
            nondisplay = (fg == lad_pkg::COL_WHITE);
        end else if (bg == lad_pkg::COL_BLACK) begin
            underscore = mono && (fg == lad_pkg::COL_BLUE);
        end else begin
            rev = 1'b1;
        end
        // Intensity never changes the two levels themselves, only the treatment
        if (intens && !nondisplay && !solid_grey) begin
            case (lad_pkg::lad_intens_e'(intens_mode))
                lad_pkg::LAD_INT_REVERSE:   rev        = !rev;
                lad_pkg::LAD_INT_UNDERLINE: underscore = 1'b1;
                lad_pkg::LAD_INT_ALTFONT:   alt_font   = 1'b1;
                default:                    ;
            endcase
        end
        if (rev) begin
            fg_dark = 1'b0;
            bg_dark = 1'b1;
        end
    end

endmodule : lad_attr_decode
`default_nettype wire

/* File: tb/lad_core_monitor.sv */
// Port checker for the LCD attribute decoder core
`timescale 1ns/100ps
`default_nettype none
module lad_core_monitor #(
    parameter int CELL_AW = 12
) (
    input wire logic       clk,
    input wire logic       reset,
    input wire logic       mono_cfg_we,
    input wire logic [1:0] cfg_intens,
    input wire logic       host_busy,
    input wire logic       host_ack,
    input wire logic       disp_req,
    input wire logic [2:0] disp_row,
    input wire logic       graphics,
    input wire logic       cell_valid,
    input wire logic [7:0] cell_char,
    input wire logic       cell_grey,
    input wire logic       cell_underscore,
    input wire logic       cell_nondisplay,
    input wire logic [1:0] mono_intens
);
    default clocking mcb @(posedge clk);
    endclocking
    default disable iff (reset);
    // Steps of a fetch and of a host take
    sequence fetch_s;
        disp_req ##2 cell_valid;
    endsequence
    sequence take_s;
        $rose(host_busy);
    endsequence
    // Fetch timing and display hold
    fetch_time_a: assert property (disp_req |-> fetch_s)
        else $error("fetch answer late");
    valid_cause_a: assert property (cell_valid |-> $past(disp_req, 2))
        else $error("stray cell valid");
    cell_hold_a: assert property (!cell_valid |-> $stable(cell_char) && $stable(cell_underscore))
        else $error("cell output moved");
    // Host completion
    host_done_a: assert property (take_s |-> ##[1:40] host_ack)
        else $error("host access not done");
    busy_hold_a: assert property (host_busy |=> host_busy || host_ack)
        else $error("busy dropped without ack");
    // Cell rendering
    ul_row_a: assert property (cell_valid && cell_underscore |-> $past(disp_row, 2) == lad_pkg::UL_ROW)
        else $error("underscore off last row");
    grey_hidden_a: assert property (cell_valid && cell_grey && !$past(graphics, 2) |-> cell_nondisplay)
        else $error("grey cell shown");
    // Intensity setting
    intens_load_a: assert property (mono_cfg_we |=> mono_intens == $past(cfg_intens))
        else $error("setting not loaded");
    intens_keep_a: assert property (!mono_cfg_we |=> $stable(mono_intens))
        else $error("setting moved");
endmodule : lad_core_monitor
`default_nettype wire

/* File: tb/lad_host_model.sv */
// Host processor model making refresh buffer byte accesses
`timescale 1ns/100ps
`default_nettype none
module lad_host_model #(
    parameter int CELL_AW = 4
) (
    input  wire logic               clk,
    input  wire logic               host_ack,
    input  wire logic [7:0]         host_rdata,
    output logic                    host_req,
    output logic                    host_we,
    output logic [CELL_AW:0]        host_addr,
    output logic [7:0]              host_wdata
);
    // Idle lines at start
    initial begin
        host_req   = 1'b0;
        host_we    = 1'b0;
        host_addr  = '0;
        host_wdata = 8'h00;
    end
    // One byte access at any moment, no sync wait, held until acknowledged
    task automatic access(input logic we, input logic [CELL_AW:0] addr, input logic [7:0] wdata,
                          input int gap, output logic [7:0] rdata);
        int n;
        n = 0;
        repeat (gap) @(posedge clk);
        @(posedge clk);
        host_req   <= 1'b1;
        host_we    <= we;
        host_addr  <= addr;
        host_wdata <= wdata;
        do begin
            @(posedge clk);
            n++;
        end while (host_ack !== 1'b1 && n < 50);
        rdata = (host_ack === 1'b1) ? host_rdata : 8'hXX; // Taken at the edge that sees the ack
        host_req   <= 1'b0;
        host_addr  <= ~addr;  // Released lines show no stale value
        host_wdata <= ~wdata;
    endtask : access
endmodule : lad_host_model
`default_nettype wire

/* File: tb/lad_core_bench.sv */
// Self-checking bench for the LCD attribute decoder core
`timescale 1ns/100ps
`default_nettype none
module lad_core_bench;
    logic        clk, reset, emul_colour, graphics, palette, mono_cfg_we, colour_cfg_we, disp_req;
    logic [2:0]  gfx_bg, disp_row;
    logic [1:0]  cfg_intens, mono_intens, colour_intens;
    logic [3:0]  disp_cell;
    logic        host_req, host_we, host_busy, host_ack, cell_valid, fg, bg, grey, ul, alt, nd;
    logic [4:0]  host_addr;
    logic [7:0]  host_wdata, host_rdata, cell_char, r;
    logic [15:0] gfx_shade;
    int          failures, n_checks;
    // Core with a small buffer, and the host model
    lad_core #(.CELL_AW(4)) i_lad_core (.clk, .reset, .emul_colour, .graphics, .palette, .gfx_bg,
        .mono_cfg_we, .colour_cfg_we, .cfg_intens, .host_req, .host_we, .host_addr, .host_wdata, .host_busy,
        .host_ack, .host_rdata, .disp_req, .disp_cell, .disp_row, .cell_valid, .cell_char, .cell_fg_dark(fg),
        .cell_bg_dark(bg), .cell_grey(grey), .cell_underscore(ul), .cell_alt_font(alt), .cell_nondisplay(nd),
        .gfx_shade, .mono_intens, .colour_intens);
    lad_host_model #(.CELL_AW(4)) i_lad_host_model (.clk, .host_ack, .host_rdata, .host_req, .host_we,
        .host_addr, .host_wdata);
    // Clock of 40 ns
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Compare one result
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t mismatch got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Verdict and end of run
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : close_out
    // One display fetch, answer two edges on
    task automatic fetch(input logic [3:0] c, input logic [2:0] row);
        @(posedge clk);
        disp_req  <= 1'b1;
        disp_cell <= c;
        disp_row  <= row;
        @(posedge clk);
        disp_req  <= 1'b0;
        @(posedge clk);
        #1;
        chk(cell_valid, 1'b1);
    endtask : fetch
    // Store a text cell, fetch it, judge char and flags
    task automatic text_cell(input logic [3:0] c, input logic [7:0] ch, at, input logic [2:0] row,
                             input logic [5:0] e);
        i_lad_host_model.access(1'b1, {c, lad_pkg::LANE_CHAR}, ch, 0, r);
        i_lad_host_model.access(1'b1, {c, lad_pkg::LANE_ATTR}, at, 1, r);
        fetch(c, row);
        chk({cell_char, 2'h0, fg, bg, grey, ul, alt, nd}, {ch, 2'h0, e});
    endtask : text_cell
    // Attribute table and same-colour cases
    task automatic t_table;
        logic [7:0] at [7] = '{8'h00, 8'h01, 8'h07, 8'h70, 8'h77, 8'h22, 8'h2A};
        logic [5:0] ex [7] = '{6'h09, 6'h24, 6'h20, 6'h10, 6'h31, 6'h30, 6'h30};
        for (int i = 0; i < 7; i++) begin
            text_cell(4'(i), 8'h40 + 8'(i), at[i], 3'h7, ex[i]);
        end
        fetch(4'h1, 3'h0);
        chk({ul, fg}, 2'h1);
        i_lad_host_model.access(1'b0, {4'h3, lad_pkg::LANE_ATTR}, 8'h00, 2, r);
        chk(r, 8'h70);
    endtask : t_table
    // Every intensity treatment on an intensified normal cell
    task automatic t_intens;
        logic [5:0] ex [4] = '{6'h10, 6'h24, 6'h22, 6'h20};
        for (int m = 0; m < 4; m++) begin
            @(posedge clk);
            cfg_intens  <= 2'(m);
            mono_cfg_we <= 1'b1;
            @(posedge clk);
            mono_cfg_we <= 1'b0;
            #1;
            chk({mono_intens, colour_intens}, {2'(m), 2'h3});
            text_cell(4'h8, 8'h55, 8'h0F, 3'h7, ex[m]);
        end
    endtask : t_intens
    // Separate banks and settings per emulation
    task automatic t_banks;
        @(posedge clk);
        emul_colour   <= 1'b1;
        colour_cfg_we <= 1'b1;
        cfg_intens    <= 2'h0;
        @(posedge clk);
        colour_cfg_we <= 1'b0;
        text_cell(4'h1, 8'h43, 8'h0F, 3'h7, 6'h10);
        chk(mono_intens, 2'h3);
        @(posedge clk);
        emul_colour <= 1'b0;
        fetch(4'h1, 3'h7);
        chk({cell_char, fg, bg, ul}, {8'h41, 3'h5});
    endtask : t_banks
    // Host write colliding with back-to-back fetches
    task automatic t_contend;
        fork
            i_lad_host_model.access(1'b1, {4'h2, lad_pkg::LANE_CHAR}, 8'hA5, 0, r);
            begin
                @(posedge clk);
                disp_req  <= 1'b1;
                disp_cell <= 4'h0;
                repeat (6) @(posedge clk);
                disp_req  <= 1'b0;
            end
        join
        repeat (2) @(posedge clk);
        #1;
        chk({cell_char, 2'h0, fg, bg, grey, ul, alt, nd}, 16'h4009);
        i_lad_host_model.access(1'b0, {4'h2, lad_pkg::LANE_CHAR}, 8'h00, 0, r);
        chk(r, 8'hA5);
    endtask : t_contend
    // Graphics pels in both palettes
    task automatic t_gfx;
        for (int p = 0; p < 2; p++) begin
            @(posedge clk);
            graphics <= 1'b1;
            palette  <= p[0];
            gfx_bg   <= p[0] ? 3'h5 : 3'h2;
            text_cell(4'h3, 8'h1B, 8'hE4, 3'h0, 6'h00);
            chk(gfx_shade, 16'h1BE4);
        end
        @(posedge clk);
        graphics <= 1'b0;
    endtask : t_gfx
    // Main sequence
    initial begin
        {reset, emul_colour, graphics, palette, mono_cfg_we, colour_cfg_we, disp_req} = 7'h40;
        {gfx_bg, disp_row, cfg_intens, disp_cell} = 12'h000;
        failures = 0;
        n_checks = 0;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        #1;
        chk({mono_intens, colour_intens, cell_valid, fg, bg, grey, ul, nd}, 10'h3C0);
        t_table;
        t_intens;
        t_contend;
        t_banks;
        t_gfx;
        close_out;
    end
    // Watchdog
    initial begin
        repeat (3000) @(posedge clk);
        failures++;
        close_out;
    end
endmodule : lad_core_bench
bind lad_core lad_core_monitor #(.CELL_AW(CELL_AW)) i_lad_core_monitor (.clk, .reset, .mono_cfg_we, .cfg_intens,
    .host_busy, .host_ack, .disp_req, .disp_row, .graphics, .cell_valid, .cell_char, .cell_grey, .cell_underscore,
    .cell_nondisplay, .mono_intens);
`default_nettype wire
